// ==== pui_user_id_inj.sv ====
`timescale 1ns/1ps
module pui_user_id_inj
   import pui_pkg::*;
#(
   parameter logic [7:0] REVISION = 8'h01 // Arbitrary value
)
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // Control bus
   input  wire logic [7:0] busAddr,
   input  wire logic       busRead,
   input  wire logic       busWrite,
   input  wire logic [7:0] busWdata,
   output logic      [7:0] busRdata,
   // Write reject event to the interrupt condition register
   output logic            writeRejectSet,
   // Transmit state and threshold
   input  wire logic [1:0] injectionControlField,
   input  wire logic [7:0] injectionThreshold,
   input  wire logic       thresholdWrite,
   // User pins
   input  wire logic       senseIn0,
   input  wire logic       senseIn1,
   output logic            enableOut0,
   output logic            enableOut1
);
   import pui_pkg::*;

   logic       qual0;
   logic       qual1;
   logic       senseLatch0;
   logic       senseLatch1;
   logic       enableCtl0;
   logic       enableCtl1;
   logic [7:0] injectionCount;
   logic [7:0] injectionSnapshot;
   logic [$clog2(INJ_STEP_CYC+1)-1:0] stepCount;
   logic       stepTick;
   logic       counterActive;
   logic       userWrite;

   // ----------------------------------------------------------
   // Sense qualification
   // ----------------------------------------------------------
   pui_sense_qual u_qual0
   (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .senseIn   (senseIn0),
      .qualified (qual0)
   );

   pui_sense_qual u_qual1
   (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .senseIn   (senseIn1),
      .qualified (qual1)
   );

   assign userWrite = busWrite && (busAddr == ADDR_USER_SENSE_ENABLE);

   // ----------------------------------------------------------
   // User register
   // ----------------------------------------------------------
   // Set beats a clearing write so no event is lost
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         senseLatch0 <= RESET_BYTE[BIT_SENSE_0];
         senseLatch1 <= RESET_BYTE[BIT_SENSE_1];
      end
      else
      begin
         if (qual0)
            senseLatch0 <= 1'b1;
         else if (userWrite && !busWdata[BIT_SENSE_0])
            senseLatch0 <= 1'b0;
         if (qual1)
            senseLatch1 <= 1'b1;
         else if (userWrite && !busWdata[BIT_SENSE_1])
            senseLatch1 <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         enableCtl0 <= RESET_BYTE[BIT_ENABLE_0];
         enableCtl1 <= RESET_BYTE[BIT_ENABLE_1];
      end
      else if (userWrite)
      begin
         enableCtl0 <= busWdata[BIT_ENABLE_0];
         enableCtl1 <= busWdata[BIT_ENABLE_1];
      end
   end

   assign enableOut0 = enableCtl0;
   assign enableOut1 = enableCtl1;

   // ----------------------------------------------------------
   // Injection counter
   // ----------------------------------------------------------
   assign counterActive = (injectionControlField == INJ_ONE_SHOT)
                       || (injectionControlField == INJ_PERIODIC);
   assign stepTick = counterActive && (stepCount == $bits(stepCount)'(INJ_STEP_CYC - 1));

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || !counterActive)
         stepCount <= '0;
      else if (stepTick)
         stepCount <= '0;
      else
         stepCount <= stepCount + 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         injectionCount <= RESET_BYTE;
      else if (thresholdWrite)
         injectionCount <= injectionThreshold;
      else if (stepTick)
      begin
         if (injectionCount == 8'h00)
            injectionCount <= injectionThreshold;
         else
            injectionCount <= injectionCount - 8'h01;
      end
   end

   // ----------------------------------------------------------
   // Read path and write reject
   // ----------------------------------------------------------
   always_comb
   begin
      injectionSnapshot = injectionCount;
   end

   // Reads return data one cycle after the read strobe
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         busRdata <= RESET_BYTE;
      else if (busRead)
      begin
         case (busAddr)
            ADDR_USER_SENSE_ENABLE: busRdata <= {4'h0, enableCtl1, enableCtl0, senseLatch1, senseLatch0};
            ADDR_REVISION_IDENT:    busRdata <= REVISION;
            ADDR_INJECTION_COUNT:   busRdata <= injectionSnapshot;
            default:                busRdata <= RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         writeRejectSet <= 1'b0;
      else
         writeRejectSet <= busWrite && ((busAddr == ADDR_REVISION_IDENT)
                                     || (busAddr == ADDR_INJECTION_COUNT));
   end

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   a_sense_sticks: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(senseIn0) && senseLatch0 && !busWrite |=> senseLatch0)
      else $error("sense bit dropped without write");
   a_sense_qual: assert property (@(posedge ref_clk) disable iff (!rst_n)
      senseIn0 [*4] ##3 1'b1 |=> senseLatch0)
      else $error("sense bit not set after qualification");
   a_sense_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      userWrite && !busWdata[BIT_SENSE_0] && !qual0 |=> !senseLatch0)
      else $error("sense bit not cleared by write");
   a_enable_reset: assert property (@(posedge ref_clk)
      !rst_n |=> !enableOut0 && !enableOut1)
      else $error("enable outputs not cleared by reset");
   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      busRead && busAddr == ADDR_USER_SENSE_ENABLE |=> busRdata[7:4] == 4'h0)
      else $error("reserved bits read nonzero");
   a_enable_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
      userWrite |=> enableOut0 == $past(busWdata[BIT_ENABLE_0]))
      else $error("enable out 0 mismatch");
   a_enable1_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
      userWrite |=> enableOut1 == $past(busWdata[BIT_ENABLE_1]))
      else $error("enable out 1 mismatch");
   a_reject_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      busWrite && busAddr == ADDR_REVISION_IDENT |=> writeRejectSet)
      else $error("revision write not rejected");
   a_count_reject: assert property (@(posedge ref_clk) disable iff (!rst_n)
      busWrite && busAddr == ADDR_INJECTION_COUNT
         |=> writeRejectSet && ($stable(injectionCount) || $past(stepTick) || $past(thresholdWrite)))
      else $error("count write not rejected");
   a_snapshot_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      busRead && busAddr == ADDR_INJECTION_COUNT |=> busRdata == $past(injectionCount))
      else $error("count snapshot wrong");
   a_count_reset: assert property (@(posedge ref_clk)
      !rst_n |=> injectionCount == 8'h00)
      else $error("counter not zero after reset");
   a_count_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !counterActive && !thresholdWrite |=> $stable(injectionCount))
      else $error("counter moved while inactive");
   a_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
      stepTick && !thresholdWrite && injectionCount != 8'h00 |=> injectionCount == $past(injectionCount) - 8'h01)
      else $error("counter decrement wrong");
   a_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
      thresholdWrite |=> injectionCount == $past(injectionThreshold))
      else $error("threshold reload missed");
   a_reload_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      stepTick && !thresholdWrite && injectionCount == 8'h00 |=> injectionCount == $past(injectionThreshold))
      else $error("reload at zero missed");
   a_read_rev: assert property (@(posedge ref_clk) disable iff (!rst_n)
      busRead && busAddr == ADDR_REVISION_IDENT |=> busRdata == REVISION)
      else $error("revision read wrong");
endmodule

// ==== pui_pkg.sv ====
package pui_pkg;
   // ----------------------------------------------------------
   // Register map
   // ----------------------------------------------------------
   localparam logic [7:0] ADDR_USER_SENSE_ENABLE = 8'h17;
   localparam logic [7:0] ADDR_REVISION_IDENT    = 8'h18;
   localparam logic [7:0] ADDR_INJECTION_COUNT   = 8'h19;
   localparam int         BIT_SENSE_0            = 0;
   localparam int         BIT_SENSE_1            = 1;
   localparam int         BIT_ENABLE_0           = 2;
   localparam int         BIT_ENABLE_1           = 3;
   localparam logic [7:0] RESET_BYTE             = 8'h00;
   localparam logic [1:0] INJ_ONE_SHOT           = 2'h1;
   localparam logic [1:0] INJ_PERIODIC           = 2'h2;
   // ----------------------------------------------------------
   // Timing
   // ----------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 40;
   localparam int SENSE_QUAL_NS   = 160;
   localparam int SENSE_QUAL_CYC  = (SENSE_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INJ_STEP_NS     = 80;
   localparam int INJ_STEP_CYC    = (INJ_STEP_NS / CLK_PERIOD_NS) < 1 ? 1 : INJ_STEP_NS / CLK_PERIOD_NS;
endpackage

// ==== pui_sense_qual.sv ====
`timescale 1ns/1ps
module pui_sense_qual
   import pui_pkg::*;
#(
   parameter int QUAL_CYC = SENSE_QUAL_CYC
)
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Pin
   input  wire logic senseIn,
   // Result
   output logic      qualified
);
   localparam int CW = $clog2(QUAL_CYC + 1);
   logic          syncA;
   logic          syncB;
   logic [CW-1:0] highCount;

   // ----------------------------------------------------------
   // Synchroniser and run-length counter
   // ----------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         syncA <= 1'b0;
         syncB <= 1'b0;
      end
      else
      begin
         syncA <= senseIn;
         syncB <= syncA;
      end
   end

   // Saturates so a long pulse keeps reporting qualified
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         highCount <= '0;
      else if (!syncB)
         highCount <= '0;
      else if (highCount != CW'(QUAL_CYC))
         highCount <= highCount + CW'(1);
   end

   assign qualified = (highCount == CW'(QUAL_CYC));
endmodule

// ==== pui_user_logic_model.sv ====
`timescale 1ns/1ps
module pui_user_logic_model
(
   // Clock
   input  wire logic       ref_clk,
   // Pulse request
   input  wire logic       pulseStart,
   input  wire logic [1:0] pulseSel,
   input  wire logic [7:0] pulseLen,
   // Sense pins
   output logic            senseIn0,
   output logic            senseIn1
);
   logic [7:0] left = 8'h00;
   // Pins change off the sampling edge, so the width is whole cycles
   always @(negedge ref_clk)
   begin
      if (pulseStart)
         left <= pulseLen;
      else if (left != 8'h00)
         left <= left - 8'h01;
   end
   // Idle low between events, as the pins are pushed only by event logic
   assign senseIn0 = pulseSel[0] && (left != 8'h00);
   assign senseIn1 = pulseSel[1] && (left != 8'h00);
endmodule

// ==== tb_pui_user_id_inj.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin mismatches++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_pui_user_id_inj;
   import pui_pkg::*;
   localparam logic [7:0] REV = 8'h5a; // Arbitrary value
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  busAddr = 8'h00;
   logic        busRead = 1'b0;
   logic        busWrite = 1'b0;
   logic [7:0]  busWdata = 8'h00;
   logic [7:0]  busRdata;
   logic        writeRejectSet;
   logic [1:0]  injectionControlField = 2'h0;
   logic [7:0]  injectionThreshold = 8'h00;
   logic        thresholdWrite = 1'b0;
   logic        senseIn0;
   logic        senseIn1;
   logic        enableOut0;
   logic        enableOut1;
   logic        pulseStart = 1'b0;
   logic [1:0]  pulseSel = 2'h0;
   logic [7:0]  pulseLen = 8'h00;
   logic [31:0] seed = 32'h0000_b4ec;
   logic [7:0]  q;
   logic [7:0]  t;
   logic        rj;
   int          mismatches = 0;
   int          samplesChecked = 0;
   always #20 ref_clk = ~ref_clk;
   pui_user_id_inj #(.REVISION(REV)) pui_user_id_inj_i (.ref_clk(ref_clk), .rst_n(rst_n), .busAddr(busAddr),
      .busRead(busRead), .busWrite(busWrite), .busWdata(busWdata), .busRdata(busRdata),
      .writeRejectSet(writeRejectSet), .injectionControlField(injectionControlField),
      .injectionThreshold(injectionThreshold), .thresholdWrite(thresholdWrite), .senseIn0(senseIn0),
      .senseIn1(senseIn1), .enableOut0(enableOut0), .enableOut1(enableOut1));
   pui_user_logic_model pui_user_logic_model_i (.ref_clk(ref_clk), .pulseStart(pulseStart),
      .pulseSel(pulseSel), .pulseLen(pulseLen), .senseIn0(senseIn0), .senseIn1(senseIn1));
   // ----------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [7:0] user_exp(input logic [7:0] d, input logic [1:0] s);
      return {4'h0, d[3:2], s};
   endfunction
   // One access; the answer is taken half a cycle after the taking edge
   task automatic bus_op(input logic [7:0] a, input logic r, input logic [7:0] d);
      @(negedge ref_clk);
      busAddr <= a;
      busRead <= r;
      busWrite <= !r;
      busWdata <= d;
      @(negedge ref_clk);
      busRead <= 1'b0;
      busWrite <= 1'b0;
      q = busRdata;
      rj = writeRejectSet;
   endtask
   task automatic load_thr(input logic [7:0] v, input logic [1:0] m);
      @(negedge ref_clk);
      injectionThreshold <= v;
      thresholdWrite <= 1'b1;
      injectionControlField <= m;
      @(negedge ref_clk);
      thresholdWrite <= 1'b0;
   endtask
   task automatic pulse(input logic [1:0] s, input logic [7:0] n);
      @(negedge ref_clk);
      pulseSel <= s;
      pulseLen <= n;
      pulseStart <= 1'b1;
      @(negedge ref_clk);
      pulseStart <= 1'b0;
      repeat (12) @(negedge ref_clk);
   endtask
   task automatic give_verdict();
      if (mismatches == 0 && samplesChecked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------
   initial
   begin
      repeat (8) @(negedge ref_clk);
      rst_n <= 1'b1;
      bus_op(ADDR_INJECTION_COUNT, 1'b1, 8'h00);
      `CHK("count reset", 8'h00, q)
      bus_op(ADDR_USER_SENSE_ENABLE, 1'b1, 8'h00);
      `CHK("user reset", RESET_BYTE, q)
      `CHK("enables reset", 2'h0, {enableOut1, enableOut0})
      bus_op(ADDR_REVISION_IDENT, 1'b0, 8'hff);
      `CHK("revision reject", 1'b1, rj)
      bus_op(ADDR_INJECTION_COUNT, 1'b0, 8'h55);
      `CHK("count reject", 1'b1, rj)
      bus_op(ADDR_REVISION_IDENT, 1'b1, 8'h00);
      `CHK("revision", REV, q)
      repeat (8)
      begin
         seed = next_rand(seed);
         bus_op(ADDR_USER_SENSE_ENABLE, 1'b0, seed[7:0]);
         `CHK("user reject", 1'b0, rj)
         `CHK("enable 0", seed[2], enableOut0)
         `CHK("enable 1", seed[3], enableOut1)
         bus_op(ADDR_USER_SENSE_ENABLE, 1'b1, 8'h00);
         `CHK("user readback", user_exp(seed[7:0], 2'h0), q)
         bus_op({3'h1, seed[12:8]}, 1'b1, 8'h00);
         `CHK("unmapped", 8'h00, q)
      end
      bus_op(ADDR_USER_SENSE_ENABLE, 1'b0, 8'h00);
      // 120 ns is short of qualification on both pins
      pulse(2'h3, 8'h03);
      bus_op(ADDR_USER_SENSE_ENABLE, 1'b1, 8'h00);
      `CHK("short pulse", 8'h00, q)
      for (logic [1:0] s = 2'h1; s != 2'h3; s++)
      begin
         pulse(s, 8'h05);
         bus_op(ADDR_USER_SENSE_ENABLE, 1'b0, 8'h03);
         bus_op(ADDR_USER_SENSE_ENABLE, 1'b1, 8'h00);
         `CHK("sense kept", user_exp(8'h00, s), q)
         bus_op(ADDR_USER_SENSE_ENABLE, 1'b0, 8'h00);
         bus_op(ADDR_USER_SENSE_ENABLE, 1'b1, 8'h00);
         `CHK("sense cleared", 8'h00, q)
      end
      seed = next_rand(seed);
      t = {1'b1, seed[6:0]};
      load_thr(t, 2'h0);
      repeat (10) @(negedge ref_clk);
      bus_op(ADDR_INJECTION_COUNT, 1'b1, 8'h00);
      `CHK("count held", t, q)
      for (logic [1:0] m = 2'h1; m != 2'h0; m++)
      begin
         load_thr(t, m);
         repeat (20) @(negedge ref_clk);
         bus_op(ADDR_INJECTION_COUNT, 1'b1, 8'h00);
         `CHK("count step", 1'b1, (m == 2'h3) ? (q == t) : (q >= t - 8'h0c && q <= t - 8'h0a))
      end
      load_thr(8'h04, 2'h2);
      repeat (30) @(negedge ref_clk);
      bus_op(ADDR_INJECTION_COUNT, 1'b1, 8'h00);
      `CHK("count reload", 1'b1, q <= 8'h04)
      bus_op(ADDR_USER_SENSE_ENABLE, 1'b0, 8'h0c);
      rst_n <= 1'b0;
      injectionControlField <= 2'h0;
      repeat (3) @(negedge ref_clk);
      rst_n <= 1'b1;
      bus_op(ADDR_INJECTION_COUNT, 1'b1, 8'h00);
      `CHK("count rereset", 8'h00, q)
      `CHK("enables rereset", 2'h0, {enableOut1, enableOut0})
      give_verdict();
   end
   // Whole sequence is well under a thousand cycles
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      mismatches++;
      give_verdict();
   end
endmodule
